// ==== hdl/quad_dac_host_defines.vh ====
// offsets, fields, reset values and timing counts of the quad dac host
`ifndef QUAD_DAC_HOST_DEFINES_VH
`define QUAD_DAC_HOST_DEFINES_VH

`define ADDR_W            5
`define REG_CTRL          5'h00
`define REG_CMD           5'h04
`define REG_STATUS        5'h08
`define REG_READ_DATA     5'h0c
`define REG_SHADOW_BASE   5'h10

`define CTRL_DEV_RESET    0
`define CTRL_LOAD_HOLD    1
`define CTRL_LOAD_PULSE   2
`define CTRL_RESET_VAL    3'h1

`define CMD_DATA_MSB      11
`define CMD_SEL_LO        12
`define CMD_SEL_HI        13
`define CMD_READ          14
`define CMD_W             15

`define STAT_BUSY         0
`define STAT_READ_DONE    1
`define STAT_REFUSED      2
`define STAT_RESET_ON     3

`define DATA_W            12
`define CODE_MID_SCALE    12'h800
`define CODE_ZERO_SCALE   12'h000

`define CLK_PERIOD_NS     20
`define T_SETUP_NS        40
`define T_STROBE_NS       100
`define T_HOLD_NS         20
`define T_LOAD_NS         100
`define CYC_MIN(t)        (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYC         `CYC_MIN(`T_SETUP_NS)
`define STROBE_CYC        `CYC_MIN(`T_STROBE_NS)
`define HOLD_CYC          `CYC_MIN(`T_HOLD_NS)
`define LOAD_CYC          `CYC_MIN(`T_LOAD_NS)

`endif

// ==== hdl/phase_timer.v ====
// down counter that times one bus phase and pulses done at its end
`timescale 1ns/10ps
module phase_timer
#(
  parameter W = 8
)
(
  input  wire         clk,
  input  wire         reset,
  input  wire         start,
  input  wire [W-1:0] count,
  output wire         done
);

  reg         run_q;
  reg [W-1:0] cnt_q;

  assign done = run_q && (cnt_q == {{(W-1){1'b0}}, 1'b1});

  // a start in the cycle of done begins the next phase seamlessly
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      run_q <= 1'b0;
      cnt_q <= {W{1'b0}};
    end
    else if (start)
    begin
      run_q <= 1'b1;
      cnt_q <= count;
    end
    else if (done)
    begin
      run_q <= 1'b0;
      cnt_q <= {W{1'b0}};
    end
    else if (run_q)
    begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// ==== hdl/quad_dac_host.v ====
// host controller driving the parallel port of a quad 12-bit converter
`timescale 1ns/10ps
`include "quad_dac_host_defines.vh"

module quad_dac_host
#(
  parameter             MID_SCALE  = 1,
  parameter [7:0]       SETUP_CYC  = `SETUP_CYC,
  parameter [7:0]       STROBE_CYC = `STROBE_CYC,
  parameter [7:0]       HOLD_CYC   = `HOLD_CYC,
  parameter [7:0]       LOAD_CYC   = `LOAD_CYC
)
(
  input  wire               clk,
  input  wire               reset,
  input  wire [`ADDR_W-1:0] addr,
  input  wire [31:0]        wdata,
  input  wire               wr,
  input  wire               rd,
  output reg  [31:0]        rdata,
  output reg  [`DATA_W-1:0] data_out,
  output reg                data_oe,
  input  wire [`DATA_W-1:0] data_in,
  output reg                read_write,
  output reg                channel_select_hi,
  output reg                channel_select_lo,
  output reg                chip_select_n,
  output wire               load_converters_n,
  output wire               dev_reset_n
);

  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_SETUP  = 3'h1;
  localparam [2:0] ST_STROBE = 3'h2;
  localparam [2:0] ST_HOLD   = 3'h3;
  localparam [2:0] ST_LOAD   = 3'h4;

  localparam [`DATA_W-1:0] RESET_CODE =
    (MID_SCALE != 0) ? `CODE_MID_SCALE : `CODE_ZERO_SCALE;

  reg [2:0]             state_q;
  reg [2:0]             ctrl_q;
  reg [`CMD_W-1:0]      cmd_q;
  reg                   read_done_q;
  reg                   refused_q;
  reg                   load_pulse_q;
  reg [`DATA_W-1:0]     rd_word_q;
  reg [1:0]             rd_chan_q;
  reg [`DATA_W-1:0]     shadow_q [0:3];
  reg [7:0]             tmr_count;
  reg                   tmr_start;
  wire                  tmr_done;

  wire busy      = (state_q != ST_IDLE);
  wire dev_rst   = ctrl_q[`CTRL_DEV_RESET];
  wire cmd_wr    = wr && (addr == `REG_CMD);
  wire cmd_ok    = cmd_wr && !busy && !dev_rst;
  wire ctrl_wr   = wr && (addr == `REG_CTRL);
  wire pulse_req = ctrl_wr && wdata[`CTRL_LOAD_PULSE];
  wire pulse_ok  = pulse_req && !busy && !cmd_wr;
  wire stat_wr   = wr && (addr == `REG_STATUS);
  wire cmd_read  = cmd_q[`CMD_READ];
  wire [1:0] cmd_chan = {cmd_q[`CMD_SEL_HI], cmd_q[`CMD_SEL_LO]};

  // channel index 0..3 is a..d: hi bit picks c/d, lo bit picks b/d
  function [1:0] chan_index;
    input sel_hi;
    input sel_lo;
    begin
      chan_index = {sel_hi, sel_lo};
    end
  endfunction

  function in_window;
    input [`ADDR_W-1:0] a;
    begin
      in_window = (a >= `REG_SHADOW_BASE) &&
                  (a <= `REG_SHADOW_BASE + 5'h0c) && (a[1:0] == 2'b00);
    end
  endfunction

  phase_timer #(.W(8)) u_timer
  (
    .clk   (clk),
    .reset (reset),
    .start (tmr_start),
    .count (tmr_count),
    .done  (tmr_done)
  );

  // device reset held low from host reset until software releases it
  assign dev_reset_n = ~dev_rst;
  // hold mode keeps the converters transparent; a pulse loads them once
  assign load_converters_n =
    ~(ctrl_q[`CTRL_LOAD_HOLD] | load_pulse_q);

  always @*
  begin
    tmr_start = 1'b0;
    tmr_count = SETUP_CYC;
    case (state_q)
      ST_IDLE:
      begin
        if (cmd_ok)
        begin
          tmr_start = 1'b1;
          tmr_count = SETUP_CYC;
        end
        else if (pulse_ok)
        begin
          tmr_start = 1'b1;
          tmr_count = LOAD_CYC;
        end
      end
      ST_SETUP:
      begin
        tmr_start = tmr_done;
        tmr_count = STROBE_CYC;
      end
      ST_STROBE:
      begin
        tmr_start = tmr_done;
        tmr_count = HOLD_CYC;
      end
      default:
      begin
        tmr_start = 1'b0;
        tmr_count = SETUP_CYC;
      end
    endcase
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q           <= ST_IDLE;
      cmd_q             <= {`CMD_W{1'b0}};
      load_pulse_q      <= 1'b0;
      data_out          <= {`DATA_W{1'b0}};
      data_oe           <= 1'b0;
      read_write        <= 1'b1;
      channel_select_hi <= 1'b0;
      channel_select_lo <= 1'b0;
      chip_select_n     <= 1'b1;
      rd_word_q         <= {`DATA_W{1'b0}};
      rd_chan_q         <= 2'b00;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (cmd_ok)
          begin
            cmd_q             <= wdata[`CMD_W-1:0];
            state_q           <= ST_SETUP;
            channel_select_hi <= wdata[`CMD_SEL_HI];
            channel_select_lo <= wdata[`CMD_SEL_LO];
            read_write        <= wdata[`CMD_READ];
            data_out          <= wdata[`CMD_DATA_MSB:0];
            // never drive against the device during a readback
            data_oe           <= ~wdata[`CMD_READ];
          end
          else if (pulse_ok)
          begin
            state_q      <= ST_LOAD;
            load_pulse_q <= 1'b1;
          end
        end
        ST_SETUP:
        begin
          if (tmr_done)
          begin
            state_q       <= ST_STROBE;
            chip_select_n <= 1'b0;
          end
        end
        ST_STROBE:
        begin
          if (tmr_done)
          begin
            state_q       <= ST_HOLD;
            // word and address stay put while the latch closes
            chip_select_n <= 1'b1;
            if (cmd_read)
            begin
              rd_word_q <= data_in;
              rd_chan_q <= cmd_chan;
            end
          end
        end
        ST_HOLD:
        begin
          if (tmr_done)
          begin
            state_q    <= ST_IDLE;
            data_oe    <= 1'b0;
            read_write <= 1'b1;
          end
        end
        ST_LOAD:
        begin
          if (tmr_done)
          begin
            state_q      <= ST_IDLE;
            load_pulse_q <= 1'b0;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // host copy of each input register, updated as the strobe closes
  always @(posedge clk or posedge reset)
  begin : shadow_blk
    integer i;
    if (reset)
    begin
      for (i = 0; i < 4; i = i + 1)
        shadow_q[i] <= RESET_CODE;
    end
    else if (dev_rst)
    begin
      for (i = 0; i < 4; i = i + 1)
        shadow_q[i] <= RESET_CODE;
    end
    else if (state_q == ST_STROBE && tmr_done && !cmd_read)
    begin
      // only the addressed channel changes; the rest keep their code
      shadow_q[chan_index(cmd_q[`CMD_SEL_HI], cmd_q[`CMD_SEL_LO])] <=
        cmd_q[`CMD_DATA_MSB:0];
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_q      <= `CTRL_RESET_VAL;
      read_done_q <= 1'b0;
      refused_q   <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
      begin
        ctrl_q <= {1'b0, wdata[`CTRL_LOAD_HOLD], wdata[`CTRL_DEV_RESET]};
      end
      if (state_q == ST_STROBE && tmr_done && cmd_read)
        read_done_q <= 1'b1;
      else if (stat_wr && wdata[`STAT_READ_DONE])
        read_done_q <= 1'b0;
      if ((cmd_wr && !cmd_ok) || (pulse_req && !pulse_ok))
        refused_q <= 1'b1;
      else if (stat_wr && wdata[`STAT_REFUSED])
        refused_q <= 1'b0;
    end
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rdata <= 32'h00000000;
    end
    else if (rd)
    begin
      if (addr == `REG_CTRL)
        rdata <= {30'h00000000, ctrl_q[1:0]};
      else if (addr == `REG_CMD)
        rdata <= {17'h00000, cmd_q};
      else if (addr == `REG_STATUS)
        rdata <= {28'h0000000, dev_rst, refused_q, read_done_q, busy};
      else if (addr == `REG_READ_DATA)
        rdata <= {18'h00000, rd_chan_q, rd_word_q};
      else if (in_window(addr))
        rdata <= {20'h00000, shadow_q[addr[3:2]]};
      else
        rdata <= 32'h00000000;
    end
    else
    begin
      rdata <= 32'h00000000;
    end
  end

endmodule

// ==== testbench/quad_dac_host_monitor.sv ====
// pin-level assertions for the quad converter host
`timescale 1ns/10ps
`include "quad_dac_host_defines.vh"
module quad_dac_host_monitor
#(
  parameter [7:0] STROBE_CYC = `STROBE_CYC
)
(
  input wire               clk,
  input wire               reset,
  input wire [`ADDR_W-1:0] addr,
  input wire [31:0]        wdata,
  input wire               wr,
  input wire               rd,
  input wire [31:0]        rdata,
  input wire [11:0]        data_out,
  input wire               data_oe,
  input wire [11:0]        data_in,
  input wire               read_write,
  input wire               channel_select_hi,
  input wire               channel_select_lo,
  input wire               chip_select_n,
  input wire               load_converters_n,
  input wire               dev_reset_n
);
  reg [7:0] cs_cnt_q;
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      cs_cnt_q <= 8'h00;
    else
      cs_cnt_q <= chip_select_n ? 8'h00 : cs_cnt_q + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_strobe_len;
    $rose(chip_select_n) |-> cs_cnt_q == STROBE_CYC;
  endproperty
  a_strobe_len: assert property (p_strobe_len)
    else $error("strobe length wrong");
  property p_sel_hold;
    !chip_select_n |->
      $stable({channel_select_hi, channel_select_lo, read_write});
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("select moved in strobe");
  property p_wr_data;
    !chip_select_n && !read_write |-> data_oe && $stable(data_out);
  endproperty
  a_wr_data: assert property (p_wr_data)
    else $error("write data not held");
  property p_hold;
    $rose(chip_select_n) && !read_write |-> data_oe && $stable(data_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("no hold after strobe");
  property p_rd_float;
    read_write |-> !data_oe;
  endproperty
  a_rd_float: assert property (p_rd_float)
    else $error("bus driven on read");
  property p_rw_idle;
    chip_select_n && !data_oe |-> read_write;
  endproperty
  a_rw_idle: assert property (p_rw_idle)
    else $error("write level when idle");
  property p_setup;
    $fell(chip_select_n) && !read_write |-> $past(data_oe, 2);
  endproperty
  a_setup: assert property (p_setup)
    else $error("data setup short");
  property p_dev_quiet;
    !dev_reset_n |-> chip_select_n;
  endproperty
  a_dev_quiet: assert property (p_dev_quiet)
    else $error("access in device reset");
  property p_rdata_zero;
    !$past(rd) |-> rdata == 32'h0;
  endproperty
  a_rdata_zero: assert property (p_rdata_zero)
    else $error("read data outside slot");
endmodule
bind quad_dac_host quad_dac_host_monitor #(.STROBE_CYC(STROBE_CYC)) mon
(
  .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .data_out(data_out), .data_oe(data_oe),
  .data_in(data_in), .read_write(read_write),
  .channel_select_hi(channel_select_hi),
  .channel_select_lo(channel_select_lo), .chip_select_n(chip_select_n),
  .load_converters_n(load_converters_n), .dev_reset_n(dev_reset_n)
);

// ==== testbench/dac_port_model.sv ====
// behavioural model of the quad converter parallel port
`timescale 1ns/10ps
module dac_port_model
#(
  parameter [11:0] RST_CODE = 12'h800
)
(
  input  wire        reset_n,
  input  wire        load_n,
  input  wire        rw,
  input  wire        sel_hi,
  input  wire        sel_lo,
  input  wire        cs_n,
  input  wire [11:0] bus,
  output wire [11:0] rb_word,
  output wire        rb_oe,
  output reg  [47:0] conv
);
  reg  [47:0] inreg;
  wire [1:0]  ch = {sel_hi, sel_lo};
  assign rb_oe = !cs_n && rw;
  assign rb_word = inreg[ch*12 +: 12];
  // latches, not flops: the device has no clock
  always @*
  begin
    if (!reset_n)
    begin
      inreg = {4{RST_CODE}};
      conv = {4{RST_CODE}};
    end
    else
    begin
      if (!cs_n && !rw)
        inreg[ch*12 +: 12] = bus;
      if (!load_n)
        conv = inreg;
    end
  end
endmodule

// ==== testbench/tb_top.sv ====
// self-checking bench for the quad converter host controller
`timescale 1ns/10ps
`include "quad_dac_host_defines.vh"
module tb_top;
  reg         clk = 0;
  reg         reset = 1;
  reg  [4:0]  addr = 0;
  reg  [31:0] wdata = 0;
  reg         wr = 0;
  reg         rd = 0;
  wire [31:0] rdata;
  wire [11:0] dout;
  wire        doe;
  wire [11:0] din;
  wire        rw;
  wire        s_hi;
  wire        s_lo;
  wire        cs_n;
  wire        ld_n;
  wire        dres_n;
  wire [11:0] rb_word;
  wire        rb_oe;
  wire [47:0] conv;
  reg  [11:0] last = 0;
  reg  [31:0] v;
  reg  [11:0] w [0:3];
  integer     fails = 0;
  integer     cmp_count = 0;
  integer     ld_cnt = 0;
  integer     i;
  integer     n;
  always #10 clk = ~clk;
  // released bus shows a changing pattern, never the last word
  always @(posedge clk) last <= din;
  // counts edges with the load line low, so pulse length is exact
  always @(posedge clk)
  begin
    if (ld_n === 1'b0)
      ld_cnt <= ld_cnt + 1;
  end
  assign din = doe ? dout : rb_oe ? rb_word : ~last;
  quad_dac_host dut
  (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .data_out(dout), .data_oe(doe),
    .data_in(din), .read_write(rw), .channel_select_hi(s_hi),
    .channel_select_lo(s_lo), .chip_select_n(cs_n),
    .load_converters_n(ld_n), .dev_reset_n(dres_n)
  );
  dac_port_model dev
  (
    .reset_n(dres_n), .load_n(ld_n), .rw(rw), .sel_hi(s_hi),
    .sel_lo(s_lo), .cs_n(cs_n), .bus(din), .rb_word(rb_word),
    .rb_oe(rb_oe), .conv(conv)
  );
  task end_sim;
  begin
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  task cmp(input [127:0] name, input [47:0] exp, input [47:0] got);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("CHECK FAILED %0s exp %h got %h", name, exp, got);
    end
  end
  endtask
  task wreg(input [4:0] a, input [31:0] d);
  begin
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
    @(posedge clk);
  end
  endtask
  task rreg(input [4:0] a, output [31:0] d);
  begin
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 d = rdata;
    @(posedge clk);
  end
  endtask
  task acc(input rdf, input [1:0] ch, input [11:0] d);
  begin
    wreg(`REG_CMD, {17'h0, rdf, ch, d});
    @(posedge clk);
    v = 1;
    for (n = 0; n < 40 && v[0] !== 1'b0; n = n + 1)
      rreg(`REG_STATUS, v);
    if (v[0] !== 1'b0)
    begin
      fails = fails + 1;
      end_sim;
    end
  end
  endtask
  initial
  begin
    #1000000;
    fails = fails + 1;
    end_sim;
  end
  initial
  begin
    repeat (4) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    rreg(`REG_CTRL, v);
    cmp("ctrl", 1, v);
    for (i = 0; i < 4; i = i + 1)
    begin
      rreg(`REG_SHADOW_BASE + 4 * i, v);
      cmp("shadow", 12'h800, v);
      w[i] = 12'ha5c ^ {6{i[1:0]}};
    end
    cmp("conv", {4{12'h800}}, conv);
    wreg(`REG_CMD, 32'h123);
    rreg(`REG_STATUS, v);
    cmp("refused", 1, v[2]);
    wreg(`REG_STATUS, 32'h4);
    rreg(`REG_STATUS, v);
    cmp("ref_clr", 8, v);
    wreg(`REG_CTRL, 0);
    acc(1, 2'b10, 0);
    rreg(`REG_READ_DATA, v);
    cmp("rb_rst", {2'b10, 12'h800}, v);
    rreg(`REG_STATUS, v);
    cmp("rd_done", 1, v[1]);
    for (i = 0; i < 4; i = i + 1)
      acc(0, i, w[i]);
    for (i = 0; i < 4; i = i + 1)
    begin
      acc(1, i, 0);
      rreg(`REG_READ_DATA, v);
      cmp("rb", {i[1:0], w[i]}, v);
    end
    cmp("conv_hold", {4{12'h800}}, conv);
    n = ld_cnt;
    wreg(`REG_CTRL, 32'h4);
    repeat (8) @(posedge clk);
    cmp("ld_len", `LOAD_CYC, ld_cnt - n);
    cmp("conv_ld", {w[3], w[2], w[1], w[0]}, conv);
    wreg(`REG_CMD, {19'h0, 12'h111});
    acc(0, 1, 12'h222);
    rreg(`REG_STATUS, v);
    cmp("busy_ref", 1, v[2]);
    rreg(`REG_SHADOW_BASE + 4, v);
    cmp("sh_keep", w[1], v);
    rreg(5'h02, v);
    cmp("unmapped", 0, v);
    // hold mode: converters follow each input register as it is written
    wreg(`REG_CTRL, 2);
    rreg(`REG_CTRL, v);
    cmp("ctrl_hold", 2, v);
    acc(0, 2, 12'h3c3);
    cmp("conv_tr", {w[3], 12'h3c3, w[1], 12'h111}, conv);
    wreg(`REG_CTRL, 1);
    @(posedge clk);
    wreg(`REG_CTRL, 0);
    cmp("conv_rst", {4{12'h800}}, conv);
    acc(1, 2'b01, 0);
    rreg(`REG_READ_DATA, v);
    cmp("rb_rst2", {2'b01, 12'h800}, v);
    end_sim;
  end
endmodule
